//--- design/ssmtx_baud_div.sv
`timescale 1ns/1ns
`include "ssmtx_cfg.svh"

// Half-period tick generator: prescaler of 2^ps then divider of div+1.
module ssmtx_baud_div
  import ssmtx_pkg::*;
(
  // Clock and reset.
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  // Control.
  input  wire logic                    run,
  input  wire logic [3:0]              ps_sel,
  input  wire logic [`SSMTX_DIV_W-1:0] div,
  // One-cycle enable, once per half serial clock period.
  output logic                         tick
);

  logic [14:0]             pre_cnt_reg;  // Free prescaler count while running.
  logic [`SSMTX_DIV_W-1:0] div_cnt_reg;  // Divider count of prescaled pulses.
  logic [14:0]             pre_mask;     // Low count bits that must all be set.
  logic                    pre_en;       // Prescaled enable.

  // The mask holds ps_sel ones, so pre_en fires every 2^ps_sel cycles.
  assign pre_mask = 15'((16'h0001 << ps_sel) - 16'h0001);
  assign pre_en   = run && ((pre_cnt_reg & pre_mask) == pre_mask);
  // Half period is 2^ps*(div+1) cycles, slowest at ps=15 and div=127.
  assign tick     = pre_en && (div_cnt_reg == div); // R16

  // Both counters restart while stopped so each word begins in phase.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt_reg <= 15'h0000;
      div_cnt_reg <= 7'h00;
    end else if (!run) begin
      pre_cnt_reg <= 15'h0000;
      div_cnt_reg <= 7'h00;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 15'h0001;
      if (tick) begin
        div_cnt_reg <= 7'h00;
      end else if (pre_en) begin
        div_cnt_reg <= div_cnt_reg + 7'h01;
      end
    end
  end

endmodule

//--- design/ssmtx_top.sv
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "ssmtx_cfg.svh"

// Behaviour
// R1: clock and data out lines used only.
// R2: word length 7 or 8 bits.
// R3: serial clock at most system clock over four.
// R4: software keeps divider field at one or more.
// R5: phase 0: first bit at first clock toggle.
// R6: phase 1: first bit half period early; the code drives it a full period (two half periods) before the first toggle.
// R7: polarity 0: change on fall, sample on rise.
// R8: polarity 1: change on rise, sample on fall.
// R9: irq on word end or buffer empty.
// R10: write while buffer full overwrites pending word.
// R11: software changes irq source before last bit.
// R12: software sets idle clock level per polarity.
// R13: after enable rewrite software fully reinitialises.
// R14: software sets only its output enable bit.
// R15: start bit write enables that channel only.
// R16: rate from prescaler and divider counter.
// R17: stop bit write clears channel enable.
// R18: load clears buffer full, sets busy.
// R19: MSB or LSB first, one bit per period.
module ssmtx_top
  import ssmtx_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Avalon-MM slave.
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial pins, output only in transmission.
  output logic             serial_clock_pin,
  output logic             serial_data_out_pin,
  // Channel interrupt pulse.
  output logic             channel_irq
);

  // Register file.
  logic [7:0]   tx_data_buffer;         // Pending transmit word.
  logic [7:0]   baud_divider_reg;       // Divider in bits 7:1.
  logic [7:0]   channel_mode_reg;       // Interrupt source select.
  logic [7:0]   comm_setting_reg;       // Length, order, polarity, phase.
  logic [7:0]   serial_output_level;    // Idle data and clock levels.
  logic [7:0]   serial_output_enable;   // Data output enable per channel.
  logic [7:0]   presc_sel_reg;          // Prescaler exponent.
  logic [1:0]   op_enabled_status;      // Channel enable per channel.
  logic         buffer_full_flag;       // Buffer holds an unsent word.
  logic         tsf_reg;                // Word in the shift register.
  // Bus handshake.
  logic         ack_reg;                // Second cycle of an access.
  logic         wr_acc;                 // Write takes effect.
  logic         wr_txbuf;               // Accepted write to the buffer.
  // Shift engine.
  ssmtx_state_t state_reg;              // Engine state.
  logic [7:0]   shreg_reg;              // Word being shifted.
  logic [2:0]   bit_idx_reg;            // Bits already sent.
  logic         phase_reg;              // 0 awaits change edge, 1 sample edge.
  logic         first_reg;              // First change edge of a word.
  logic         sck_reg;                // Serial clock output.
  logic         dout_reg;               // Serial data output.
  logic         irq_reg;                // Interrupt pulse.
  logic         tick;                   // Half-period enable.
  logic         load;                   // Buffer moves to shift register.
  logic         word_end;               // Last sample edge of a word.
  logic         stop_wr;                // Stop trigger for channel 0.
  logic [2:0]   msb_idx;                // Index of the top data bit.
  logic [2:0]   pick;                   // Index of the bit now due.
  logic         load_bit;               // First bit of the buffered word.
  logic         len8;                   // Eight-bit words.
  logic         lsb_first;              // Order select.
  logic         dap;                    // Data phase select.

  assign len8      = comm_setting_reg[`SSMTX_COMM_LEN8];
  assign lsb_first = comm_setting_reg[`SSMTX_COMM_LSB];
  assign dap       = comm_setting_reg[`SSMTX_COMM_DAP];

  // Word length sets which bit is the top one.
  assign msb_idx  = len8 ? 3'h7 : 3'h6; // R2
  assign pick     = lsb_first ? bit_idx_reg : 3'(msb_idx - bit_idx_reg); // R19
  assign load_bit = lsb_first ? tx_data_buffer[0] : tx_data_buffer[msb_idx]; // R19

  // Engine events.
  assign load     = (state_reg == st_idle) && op_enabled_status[0] && buffer_full_flag;
  assign word_end = (state_reg == st_shift) && tick && phase_reg && (bit_idx_reg == msb_idx);
  assign wr_acc   = avs_write && ack_reg && avs_byteenable[0];
  assign wr_txbuf = wr_acc && (avs_address == `SSMTX_OFF_TXBUF);
  assign stop_wr  = wr_acc && (avs_address == `SSMTX_OFF_STOP) && avs_writedata[0];

  // Access waits one cycle, answering on the second.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  // Pins come straight from flip-flops.
  assign serial_clock_pin    = sck_reg; // R1
  assign serial_data_out_pin = dout_reg; // R1
  assign channel_irq         = irq_reg;

  // Half-period tick generator, running only while a word is under way.
  ssmtx_baud_div u_baud (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .run     (state_reg != st_idle),
    .ps_sel  (presc_sel_reg[3:0]),
    .div     (baud_divider_reg[7:1]),
    .tick    (tick)
  );

  // Handshake flag that separates the wait cycle from the answer cycle.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  // Read data is latched in the wait cycle and stands until the next read.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      case (avs_address)
        `SSMTX_OFF_TXBUF:  avs_readdata <= {24'h00_0000, tx_data_buffer};
        `SSMTX_OFF_BAUD:   avs_readdata <= {24'h00_0000, baud_divider_reg};
        `SSMTX_OFF_MODE:   avs_readdata <= {24'h00_0000, channel_mode_reg};
        `SSMTX_OFF_COMM:   avs_readdata <= {24'h00_0000, comm_setting_reg};
        `SSMTX_OFF_STATUS: avs_readdata <= {28'h000_0000, op_enabled_status,
                                            tsf_reg, buffer_full_flag};
        `SSMTX_OFF_START:  avs_readdata <= {30'h0000_0000, op_enabled_status};
        `SSMTX_OFF_OUTLVL: avs_readdata <= {24'h00_0000, serial_output_level};
        `SSMTX_OFF_OUTEN:  avs_readdata <= {24'h00_0000, serial_output_enable};
        `SSMTX_OFF_PRESC:  avs_readdata <= {24'h00_0000, presc_sel_reg};
        // Stop trigger and unmapped offsets read as zero.
        default:           avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Plain configuration registers.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      baud_divider_reg     <= `SSMTX_RST_BAUD;
      channel_mode_reg     <= `SSMTX_RST_MODE;
      comm_setting_reg     <= `SSMTX_RST_COMM;
      serial_output_level  <= `SSMTX_RST_OUTLVL;
      serial_output_enable <= `SSMTX_RST_OUTEN;
      presc_sel_reg        <= `SSMTX_RST_PRESC;
    end else if (wr_acc) begin
      case (avs_address)
        `SSMTX_OFF_BAUD:   baud_divider_reg     <= avs_writedata[7:0];
        // The source select may change mid-word and counts at the next event.
        `SSMTX_OFF_MODE:   channel_mode_reg     <= avs_writedata[7:0]; // R11
        `SSMTX_OFF_COMM:   comm_setting_reg     <= avs_writedata[7:0];
        `SSMTX_OFF_OUTLVL: serial_output_level  <= avs_writedata[7:0];
        `SSMTX_OFF_OUTEN:  serial_output_enable <= avs_writedata[7:0];
        `SSMTX_OFF_PRESC:  presc_sel_reg        <= {4'h0, avs_writedata[3:0]};
        // Other offsets leave the configuration alone.
        default:           presc_sel_reg        <= presc_sel_reg;
      endcase
    end
  end

  // Channel enables: start bits set, stop bits clear, each channel alone.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      op_enabled_status <= 2'b00;
    end else if (wr_acc && (avs_address == `SSMTX_OFF_START)) begin
      op_enabled_status <= op_enabled_status | avs_writedata[1:0]; // R15
    end else if (wr_acc && (avs_address == `SSMTX_OFF_STOP)) begin
      op_enabled_status <= op_enabled_status & ~avs_writedata[1:0]; // R17
    end
  end

  // Transmit buffer and its full flag; a new write wins over a load.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_data_buffer   <= 8'h00;
      buffer_full_flag <= 1'b0;
    end else if (wr_txbuf) begin
      tx_data_buffer   <= avs_writedata[7:0]; // R10
      buffer_full_flag <= 1'b1;
    end else if (load) begin
      buffer_full_flag <= 1'b0; // R18
    end
  end

  // Shift engine: load, optional lead half period, then bit periods.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= st_idle;
      shreg_reg   <= 8'h00;
      bit_idx_reg <= 3'h0;
      phase_reg   <= 1'b0;
      first_reg   <= 1'b0;
      tsf_reg     <= 1'b0;
      sck_reg     <= 1'b1;
      dout_reg    <= 1'b1;
    end else if (stop_wr) begin
      // A stop abandons any word; idle then parks the clock, and parks the data line only while its output enable is clear.
      state_reg <= st_idle;
      tsf_reg   <= 1'b0;
    end else begin
      case (state_reg)
        st_idle: begin
          // Idle clock level is software's choice matching the polarity.
          sck_reg <= serial_output_level[`SSMTX_LVL_CLK]; // R12
          if (!serial_output_enable[0]) begin
            dout_reg <= serial_output_level[`SSMTX_LVL_DATA];
          end
          if (load) begin
            shreg_reg   <= tx_data_buffer;
            bit_idx_reg <= 3'h0;
            phase_reg   <= 1'b0;
            first_reg   <= 1'b1;
            tsf_reg     <= 1'b1; // R18
            if (dap) begin
              dout_reg  <= load_bit; // R6
              state_reg <= st_lead;
            end else begin
              state_reg <= st_shift;
            end
          end
        end
        st_lead: begin
          // Data already stands; wait half a period here, then another half period in st_shift before the first toggle.
          if (tick) begin
            state_reg <= st_shift; // R6
          end
        end
        st_shift: begin
          if (tick) begin
            sck_reg <= ~sck_reg;
            if (!phase_reg) begin
              // Leading toggle: fall at polarity 0, rise at polarity 1.
              phase_reg <= 1'b1;
              first_reg <= 1'b0;
              if (!(first_reg && dap)) begin
                dout_reg <= shreg_reg[pick]; // R5 R7 R8 R19
              end
            end else begin
              // Trailing toggle is the slave's sample edge; data holds.
              phase_reg <= 1'b0;
              if (bit_idx_reg == msb_idx) begin
                state_reg <= st_idle;
                tsf_reg   <= 1'b0;
              end else begin
                bit_idx_reg <= bit_idx_reg + 3'h1; // R2
              end
            end
          end
        end
        default: begin
          state_reg <= st_idle;
        end
      endcase
    end
  end

  // Interrupt: word end in single mode, buffer empty in continuous mode.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else if (channel_mode_reg[`SSMTX_MODE_IRQSEL]) begin
      irq_reg <= load; // R9
    end else begin
      irq_reg <= word_end; // R9
    end
  end

  // Checks on the engine and the register side.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_change_tick;
    (state_reg == st_shift) && tick && !phase_reg;
  endsequence

  sequence s_sample_tick;
    (state_reg == st_shift) && tick && phase_reg;
  endsequence

  a_bit_count_len: assert property ( // R2
    (state_reg == st_shift) |-> (bit_idx_reg <= msb_idx))
    else $error("bit index beyond word length");

  a_max_rate_quarter: assert property ( // R3
    (tick && (baud_divider_reg[7:1] != 7'h00)) |=> !tick)
    else $error("serial clock faster than a quarter of the system clock");

  // The first change edge of a phase 0 word must put the first bit on the pin.
  a_phase0_first_bit: assert property ( // R5
    s_change_tick ##0 (first_reg && !dap && !stop_wr)
      |=> (dout_reg == $past(shreg_reg[pick])))
    else $error("phase 0 first bit not driven on first toggle");

  a_phase1_lead: assert property ( // R6
    (load && dap && !stop_wr) |=> (dout_reg == $past(load_bit))
      && (state_reg == st_lead) && (sck_reg == $past(sck_reg)))
    else $error("phase 1 first bit not driven ahead of the clock");

  a_sample_hold: assert property ( // R7 R8
    s_sample_tick ##0 !stop_wr |=> $stable(dout_reg) && (sck_reg != $past(sck_reg)))
    else $error("data moved on the sample edge");

  a_change_toggle: assert property ( // R7 R8
    s_change_tick ##0 !stop_wr |=> (sck_reg != $past(sck_reg)) && phase_reg)
    else $error("change edge did not toggle the clock");

  a_irq_single: assert property ( // R9
    (word_end && !channel_mode_reg[`SSMTX_MODE_IRQSEL]) |=> channel_irq)
    else $error("no transfer end interrupt");

  a_irq_cont: assert property ( // R9
    (load && channel_mode_reg[`SSMTX_MODE_IRQSEL]) |=> channel_irq ##1 !channel_irq)
    else $error("no single buffer empty interrupt");

  a_overwrite_buf: assert property ( // R10
    (wr_txbuf && buffer_full_flag) |=> (tx_data_buffer == $past(avs_writedata[7:0]))
      && buffer_full_flag)
    else $error("buffered word not overwritten");

  a_load_flags: assert property ( // R18
    (load && !wr_txbuf && !stop_wr) |=> tsf_reg && !buffer_full_flag)
    else $error("load did not move the flags");

  a_start_enable: assert property ( // R15
    (wr_acc && (avs_address == `SSMTX_OFF_START) && avs_writedata[0]) |=> op_enabled_status[0])
    else $error("start trigger did not enable the channel");

  a_stop_clear: assert property ( // R17
    stop_wr |=> !op_enabled_status[0] && (state_reg == st_idle) && !tsf_reg)
    else $error("stop trigger did not stop the channel");

endmodule

//--- inc/ssmtx_cfg.svh
`ifndef SSMTX_CFG_SVH
`define SSMTX_CFG_SVH

// Register byte offsets on the Avalon slave.
`define SSMTX_OFF_TXBUF    6'h00
`define SSMTX_OFF_BAUD     6'h04
`define SSMTX_OFF_MODE     6'h08
`define SSMTX_OFF_COMM     6'h0c
`define SSMTX_OFF_STATUS   6'h10
`define SSMTX_OFF_START    6'h14
`define SSMTX_OFF_STOP     6'h18
`define SSMTX_OFF_OUTLVL   6'h1c
`define SSMTX_OFF_OUTEN    6'h20
`define SSMTX_OFF_PRESC    6'h24

// Field positions.
`define SSMTX_COMM_LEN8    0
`define SSMTX_COMM_LSB     1
`define SSMTX_COMM_CKP     2
`define SSMTX_COMM_DAP     3
`define SSMTX_MODE_IRQSEL  0
`define SSMTX_LVL_DATA     0
`define SSMTX_LVL_CLK      4
`define SSMTX_ST_BFF       0
`define SSMTX_ST_TSF       1
`define SSMTX_ST_SE0       2
`define SSMTX_ST_SE1       3

// Reset values.
`define SSMTX_RST_BAUD     8'h02
`define SSMTX_RST_COMM     8'h01
`define SSMTX_RST_MODE     8'h00
`define SSMTX_RST_OUTLVL   8'h11
`define SSMTX_RST_OUTEN    8'h00
`define SSMTX_RST_PRESC    8'h00

// Longest prescaler exponent and divider width.
`define SSMTX_PRESC_MAX    4'hf
`define SSMTX_DIV_W        7

`endif

//--- inc/ssmtx_pkg.sv
package ssmtx_pkg;

  // Shift engine states.
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_lead  = 2'b01,
    st_shift = 2'b10
  } ssmtx_state_t;

endpackage

//--- tb/ssmtx_slave_model.sv
`timescale 1ns/1ns

// Far-side serial slave that only listens on the data line.
module ssmtx_slave_model (
  // Serial lines from the master.
  input  wire logic       serial_clock_pin,
  input  wire logic       serial_data_out_pin,
  // Set-up from the bench.
  input  wire logic       sample_on_fall,
  input  wire logic [3:0] word_len,
  input  wire logic       clr,
  // Collected words, first bit in the top of the word.
  output logic      [7:0] first_word,
  output logic      [7:0] last_word,
  output logic      [3:0] word_cnt
);
  logic [7:0] shift_reg; // Bits gathered so far.
  logic [3:0] bit_cnt;   // Bits of the current word.

  // Sample only on the sampling edge, so a wrong launch edge shows as bad bits.
  always @(posedge serial_clock_pin or negedge serial_clock_pin or posedge clr) begin
    if (clr) begin
      shift_reg = 8'h00;
      bit_cnt = 4'h0;
      word_cnt = 4'h0;
      first_word = 8'h00;
      last_word = 8'h00;
    end else if (serial_clock_pin == !sample_on_fall) begin
      shift_reg = {shift_reg[6:0], serial_data_out_pin};
      bit_cnt = bit_cnt + 4'h1;
      if (bit_cnt == word_len) begin
        if (word_cnt == 4'h0) begin
          first_word = shift_reg;
        end
        last_word = shift_reg;
        word_cnt = word_cnt + 4'h1;
        bit_cnt = 4'h0;
        shift_reg = 8'h00;
      end
    end
  end
endmodule

//--- tb/tb_ssmtx_top.sv
`timescale 1ns/1ns
`include "ssmtx_cfg.svh"

// Self-checking bench for the serial transmitter.
module tb_ssmtx_top;
  logic        sys_clk;         // System clock.
  logic        rstn;            // Active-low reset.
  logic [5:0]  avs_address;     // Bus address.
  logic        avs_read;        // Bus read request.
  logic        avs_write;       // Bus write request.
  logic [31:0] avs_writedata;   // Bus write data.
  logic [3:0]  avs_byteenable;  // Bus lane enables.
  logic [31:0] avs_readdata;    // Bus read data.
  logic        avs_waitrequest; // Bus stall.
  logic        serial_clock_pin;
  logic        serial_data_out_pin;
  logic        channel_irq;
  logic        sample_on_fall;  // Slave sampling edge.
  logic [3:0]  word_len;        // Slave word length.
  logic        clr;             // Slave clear.
  logic [7:0]  first_word;
  logic [7:0]  last_word;
  logic [3:0]  word_cnt;
  logic        prev_sck;        // Pin values one cycle back.
  logic        prev_dout;
  logic        lead_data;       // Data level just before the first toggle.
  int          toggles;         // Clock toggles since the last clear.
  int          gap;             // Cycles since the last toggle.
  int          min_half;        // Shortest clock level seen.
  int          irq_cnt;         // Interrupt pulses seen.
  int          cycles;
  int          errors;
  int          num_checks;

  ssmtx_top ssmtx_top_inst (
    .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_clock_pin(serial_clock_pin), .serial_data_out_pin(serial_data_out_pin),
    .channel_irq(channel_irq));

  ssmtx_slave_model ssmtx_slave_model_inst (
    .serial_clock_pin(serial_clock_pin), .serial_data_out_pin(serial_data_out_pin),
    .sample_on_fall(sample_on_fall), .word_len(word_len), .clr(clr),
    .first_word(first_word), .last_word(last_word), .word_cnt(word_cnt));

  // Clock of 20 ns period.
  always #10 sys_clk = ~sys_clk;

  // Pin monitor on the falling edge, where every register output has settled.
  always @(negedge sys_clk) begin
    gap <= gap + 1;
    if (channel_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
    if (serial_clock_pin !== prev_sck) begin
      if (toggles == 0) begin
        lead_data <= prev_dout;
      end else if (gap < min_half) begin
        min_half <= gap;
      end
      toggles <= toggles + 1;
      gap <= 1;
    end
    prev_sck <= serial_clock_pin;
    prev_dout <= serial_data_out_pin;
  end

  // Hang guard.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= 20000) begin
      errors++;
      finish_test();
    end
  end

  // Compares a value and reports a mismatch.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus access, held until waitrequest is sampled low at a rising edge.
  task automatic bus_access(input logic wr, input logic [5:0] a, input logic [7:0] d,
                            output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus_access(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus_access(1'b0, a, 8'h00, q);
    check(q, {24'h0, e});
  endtask

  // Polls status until the shifter and buffer are both empty.
  task automatic wait_idle;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus_access(1'b0, `SSMTX_OFF_STATUS, 8'h00, q);
      n++;
    end while (q[1:0] !== 2'b00 && n < 400);
    // A poll limit that runs out shows here as a mismatch.
    check(q & 32'h0000_0003, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
  endtask

  // Programs the channel and starts it.
  task automatic setup(input logic [7:0] comm, lvl, baud, presc, mode);
    wr(`SSMTX_OFF_COMM, comm);
    wr(`SSMTX_OFF_OUTLVL, lvl);
    wr(`SSMTX_OFF_BAUD, baud);
    wr(`SSMTX_OFF_PRESC, presc);
    wr(`SSMTX_OFF_MODE, mode);
    wr(`SSMTX_OFF_OUTEN, 8'h01);
    wr(`SSMTX_OFF_START, 8'h01);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    toggles = 0;
    min_half = 1000;
    irq_cnt = 0;
  endtask

  // Sends one word in single mode and judges pins, status and interrupt.
  task automatic send(input logic [7:0] d, exp_rx, input int len, half, input logic lead);
    wr(`SSMTX_OFF_TXBUF, d);
    rd_chk(`SSMTX_OFF_STATUS, 8'h06);
    wait_idle();
    check(first_word, exp_rx);
    check(word_cnt, 1);
    check(toggles, 2 * len);
    check(min_half, half);
    check(lead_data, lead);
    check(irq_cnt, 1);
  endtask

  task automatic t_reset;
    rd_chk(`SSMTX_OFF_BAUD, `SSMTX_RST_BAUD);
    rd_chk(`SSMTX_OFF_COMM, `SSMTX_RST_COMM);
    rd_chk(`SSMTX_OFF_MODE, `SSMTX_RST_MODE);
    rd_chk(`SSMTX_OFF_OUTLVL, `SSMTX_RST_OUTLVL);
    rd_chk(`SSMTX_OFF_OUTEN, `SSMTX_RST_OUTEN);
    rd_chk(`SSMTX_OFF_PRESC, `SSMTX_RST_PRESC);
    rd_chk(`SSMTX_OFF_STATUS, 8'h00);
    rd_chk(6'h3c, 8'h00);
    $display("test reset done");
  endtask

  // Eight bits, MSB first, fastest rate of a quarter of the system clock.
  task automatic t_msb8;
    sample_on_fall <= 1'b0;
    word_len <= 4'h8;
    setup(8'h01, 8'h11, 8'h02, 8'h00, 8'h00);
    send(8'h5a, 8'h5a, 8, 2, 1'b1);
    $display("test msb8 done");
  endtask

  // Seven bits, LSB first, reversed polarity, early data; 0x3a arrives as 0x2e.
  task automatic t_lsb7;
    sample_on_fall <= 1'b1;
    word_len <= 4'h7;
    setup(8'h0e, 8'h01, 8'h04, 8'h01, 8'h00);
    send(8'h3a, 8'h2e, 7, 6, 1'b0);
    $display("test lsb7 done");
  endtask

  // Continuous mode: overwrite of a pending word and buffer-empty interrupts.
  task automatic t_cont;
    sample_on_fall <= 1'b0;
    word_len <= 4'h8;
    setup(8'h01, 8'h11, 8'h02, 8'h00, 8'h01);
    wr(`SSMTX_OFF_TXBUF, 8'h11);
    wr(`SSMTX_OFF_TXBUF, 8'h22);
    rd_chk(`SSMTX_OFF_STATUS, 8'h07);
    wr(`SSMTX_OFF_TXBUF, 8'h33);
    wait_idle();
    check(word_cnt, 2);
    check(first_word, 8'h11);
    check(last_word, 8'h33);
    check(irq_cnt, 2);
    $display("test cont done");
  endtask

  // Stop clears the enable and no word leaves while stopped.
  task automatic t_stop;
    rd_chk(`SSMTX_OFF_START, 8'h01);
    rd_chk(`SSMTX_OFF_STATUS, 8'h04);
    wr(`SSMTX_OFF_STOP, 8'h01);
    rd_chk(`SSMTX_OFF_STATUS, 8'h00);
    toggles = 0;
    wr(`SSMTX_OFF_TXBUF, 8'h44);
    rd_chk(`SSMTX_OFF_STATUS, 8'h01);
    check(toggles, 0);
    $display("test stop done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    sample_on_fall = 1'b0;
    word_len = 4'h8;
    clr = 1'b1;
    toggles = 0;
    gap = 0;
    min_half = 1000;
    irq_cnt = 0;
    cycles = 0;
    errors = 0;
    num_checks = 0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    clr <= 1'b0;
    t_reset();
    t_msb8();
    t_lsb7();
    t_cont();
    t_stop();
    finish_test();
  end
endmodule
